/* verilog/sfsc_regs.sv */
// Status and configuration registers with identification reads of a serial flash
// ----------------------------------------------------------------
// Behaviour
// - Quad ID data MSB first on falling clock
// - ID bytes repeat while select stays low
// - Decode the four identification read opcodes
// - Status read accepted at any time
// - Opcode in eight or two clocks
// - Config read accepted at any time
// - Config byte driven while select low
// - Status bit0 shows busy engine
// - Write latch set; program/erase need it
// - Write latch clears when operation finishes
// - Protected target: reject, clear write latch
// - Protect bits written only by register write
// - Chip erase only with protect bits zero
// - Quad enable gates quad commands and lines
// - Quad enable disables pin guarded mode
// - Lock plus low pin refuses register write
// - Drive strength volatile, defaults thirty ohm
// - Top/bottom select one-time programmable
// - Preamble enable bit stored for dummy cycles
// - Wide address flag by enter/exit commands
// - Dummy count select two volatile bits
// ----------------------------------------------------------------
`timescale 1ns/1ps
module sfsc_regs
   import sfsc_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h3c, // Arbitrary value
   parameter logic [7:0] DENSITY = 8'h44, // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'h27, // Arbitrary value
   parameter logic [7:0] SIGNATURE = 8'h27 // Arbitrary value
) (
   input wire logic core_clk, // Block clock
   input wire logic rst_b, // Async reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic cs_b, // Chip select pin, active low
   input wire logic sclk, // Serial clock pin
   input wire logic [3:0] serial_io_line_rx, // Data pin levels
   output logic [3:0] serial_io_line_tx, // Data pin drive values
   output logic [3:0] serial_io_line_oe_b, // Data pin enables, low drives
   input wire logic engine_busy, // Program, erase or register write running
   input wire logic engine_done, // Engine finished, one cycle
   input wire logic region_protected, // Target of pending command is protected
   input wire logic [5:0] nv_status_bits, // Stored status bits 7..2
   input wire logic nv_tb, // Stored top/bottom select
   output logic pe_start, // Start program or erase, one cycle
   output logic [7:0] pe_cmd, // Opcode for the engine
   output logic reg_write_start, // Start register write timing, one cycle
   output logic [7:0] status_byte, // Status register
   output logic [7:0] config_byte // Configuration register
);

   typedef struct packed {
      sfsc_state_t st;
      logic quad;
      logic nv_loaded;
      logic cs_prev;
      logic sclk_prev;
      logic [7:0] status;
      logic [7:0] cfg;
      logic [7:0] op;
      logic [7:0] in_sh;
      logic [4:0] bit_cnt;
      logic addr0;
      logic [4:0] wr_cnt;
      logic [15:0] wr_data;
      logic [7:0] out_sh;
      logic [3:0] out_left;
      logic [1:0] idx;
      logic [3:0] sio_tx;
      logic [3:0] oe_b;
      logic pe_start;
      logic [7:0] pe_cmd;
      logic rw_start;
   } sfsc_regs_t;

   localparam sfsc_regs_t REGS_RST = '{
      st: S_IDLE, cs_prev: 1'b1, status: ST_RESET, cfg: CF_RESET, oe_b: 4'hf, default: '0};

   sfsc_regs_t s_q;
   sfsc_regs_t s_d;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] pins_s;
   logic cs_s;
   logic sclk_s;
   logic [3:0] sio_s;

   sfsc_sync #(.W(6)) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .async_in({~cs_b, sclk, serial_io_line_rx}),
      .sync_out(pins_s)
   );

   assign cs_s = ~pins_s[5]; // Kept inverted so reset reads as deselected, no false edge
   assign sclk_s = pins_s[4];
   assign sio_s = pins_s[3:0];

   // ----------------------------------------------------------------
   // Decoded conditions
   // ----------------------------------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic guarded;
   logic pe_op;
   logic wr_ok;
   logic pe_try;
   logic pe_block;
   logic [7:0] op_nxt;
   logic [7:0] byte_nx;
   logic [15:0] wr_nxt;
   logic [4:0] op_clks;
   logic [4:0] addr_clks;
   logic [1:0] idx_last;

   assign sclk_rise = sclk_s && !s_q.sclk_prev;
   assign sclk_fall = !sclk_s && s_q.sclk_prev;
   assign cs_rise = cs_s && !s_q.cs_prev;
   // Write-protect pin only exists while quad enable is clear
   assign guarded = s_q.status[ST_LOCK] && !sio_s[2] && !s_q.status[ST_QUAD];
   assign pe_op = (s_q.op == CMD_PAGE_PROG) || (s_q.op == CMD_SECTOR_ERASE) ||
                  (s_q.op == CMD_HALF_BLOCK_ERASE) || (s_q.op == CMD_BLOCK_ERASE) ||
                  (s_q.op == CMD_CHIP_ERASE) || (s_q.op == CMD_CHIP_ERASE_ALT);
   // Register write only completes on a whole byte boundary
   assign wr_ok = (s_q.st == S_WDATA) && !guarded &&
                  ((s_q.wr_cnt == WR_ONE_BYTE) || (s_q.wr_cnt == WR_TWO_BYTES));
   assign pe_try = (s_q.st == S_SKIP) && pe_op && s_q.status[ST_LATCH] && !engine_busy;
   assign pe_block = region_protected ||
                     (((s_q.op == CMD_CHIP_ERASE) || (s_q.op == CMD_CHIP_ERASE_ALT)) &&
                      (s_q.status[ST_PROT_HI:ST_PROT_LO] != 4'h0));
   assign op_clks = s_q.quad ? QUAD_OP_CLKS : SPI_OP_CLKS;
   assign addr_clks = s_q.quad ? QUAD_ADDR_CLKS : SPI_ADDR_CLKS;
   // Single-line form looks at line 0 only
   assign op_nxt = s_q.quad ? {s_q.in_sh[3:0], sio_s} : {s_q.in_sh[6:0], sio_s[0]};
   assign wr_nxt = s_q.quad ? {s_q.wr_data[11:0], sio_s} : {s_q.wr_data[14:0], sio_s[0]};
   assign idx_last = (s_q.op == CMD_MAKER_DEV_READ) ? PAIR_LAST : ID_LAST;

   always_comb begin
      case (s_q.op)
         CMD_STATUS_READ: byte_nx = s_q.status;
         CMD_CONFIG_READ: byte_nx = s_q.cfg;
         CMD_SIG_READ: byte_nx = SIGNATURE;
         CMD_MAKER_DEV_READ: byte_nx = (s_q.idx[0] ^ s_q.addr0) ? DEVICE_CODE : MAKER_CODE;
         CMD_ID_READ, CMD_QUAD_ID_READ: begin
            case (s_q.idx)
               2'h0: byte_nx = MAKER_CODE;
               2'h1: byte_nx = MEM_TYPE;
               default: byte_nx = DENSITY;
            endcase
         end
         default: byte_nx = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.pe_start = 1'b0;
      s_d.rw_start = 1'b0;
      s_d.cs_prev = cs_s;
      s_d.sclk_prev = sclk_s;
      s_d.status[ST_BUSY] = engine_busy;
      if (!s_q.status[ST_QUAD]) begin
         s_d.quad = 1'b0;
      end
      // Non-volatile bits are taken after reset release, never under reset
      if (!s_q.nv_loaded) begin
         s_d.status[ST_LOCK:ST_PROT_LO] = nv_status_bits;
         s_d.cfg[CF_TB] = nv_tb;
         s_d.nv_loaded = 1'b1;
      end
      if (engine_done) begin
         s_d.status[ST_LATCH] = 1'b0;
      end
      if (cs_s) begin
         s_d.st = S_IDLE;
         s_d.oe_b = 4'hf;
         if (cs_rise && wr_ok) begin
            s_d.rw_start = 1'b1;
            if (s_q.wr_cnt == WR_ONE_BYTE) begin
               s_d.status[ST_LOCK:ST_PROT_LO] = s_q.wr_data[7:2];
            end else begin
               s_d.status[ST_LOCK:ST_PROT_LO] = s_q.wr_data[15:10];
               s_d.cfg[CF_DRIVE_HI:0] = s_q.wr_data[2:0];
               s_d.cfg[CF_TB] = s_q.cfg[CF_TB] | s_q.wr_data[3];
               s_d.cfg[CF_PREAMBLE] = s_q.wr_data[4];
               s_d.cfg[7:CF_DUMMY_LO] = s_q.wr_data[7:6];
            end
         end
         if (cs_rise && pe_try) begin
            if (pe_block) begin
               s_d.status[ST_LATCH] = 1'b0;
            end else begin
               s_d.pe_start = 1'b1;
               s_d.pe_cmd = s_q.op;
            end
         end
      end else if (s_q.cs_prev) begin
         s_d.st = S_CMD;
         s_d.bit_cnt = 5'h00;
         s_d.in_sh = 8'h00;
         s_d.wr_cnt = 5'h00;
         s_d.idx = 2'h0;
         s_d.out_left = 4'h0;
      end else if (sclk_rise) begin
         case (s_q.st)
            S_CMD: begin
               s_d.in_sh = op_nxt;
               s_d.bit_cnt = s_q.bit_cnt + 5'h01;
               if (s_d.bit_cnt == op_clks) begin
                  s_d.op = op_nxt;
                  s_d.bit_cnt = 5'h00;
                  s_d.st = S_SKIP;
                  // While busy only the two register reads are decoded
                  if (engine_busy && (op_nxt != CMD_STATUS_READ) &&
                      (op_nxt != CMD_CONFIG_READ)) begin
                     s_d.op = CMD_NONE;
                  end else begin
                     case (op_nxt)
                        CMD_STATUS_READ, CMD_CONFIG_READ, CMD_SIG_READ: begin
                           s_d.st = S_OUT;
                        end
                        CMD_ID_READ: begin
                           if (!s_q.quad) begin
                              s_d.st = S_OUT;
                           end
                        end
                        CMD_QUAD_ID_READ: begin
                           if (s_q.quad) begin
                              s_d.st = S_OUT;
                           end
                        end
                        CMD_MAKER_DEV_READ: s_d.st = S_ADDR;
                        CMD_LATCH_SET: s_d.status[ST_LATCH] = 1'b1;
                        CMD_LATCH_CLR: s_d.status[ST_LATCH] = 1'b0;
                        CMD_REG_WRITE: begin
                           if (s_q.status[ST_LATCH]) begin
                              s_d.st = S_WDATA;
                           end
                        end
                        CMD_WIDE_ENTER: s_d.cfg[CF_WIDE] = 1'b1;
                        CMD_WIDE_EXIT: s_d.cfg[CF_WIDE] = 1'b0;
                        CMD_QUAD_ENTER: s_d.quad = s_q.status[ST_QUAD];
                        CMD_QUAD_EXIT: s_d.quad = 1'b0;
                        default: ;
                     endcase
                  end
               end
            end
            S_ADDR: begin
               s_d.bit_cnt = s_q.bit_cnt + 5'h01;
               s_d.addr0 = sio_s[0];
               if (s_d.bit_cnt == addr_clks) begin
                  s_d.st = S_OUT;
               end
            end
            S_WDATA: begin
               s_d.wr_data = wr_nxt;
               // Past two bytes the count parks above the limit and the write is dropped
               if (s_q.wr_cnt <= WR_TWO_BYTES) begin
                  s_d.wr_cnt = s_q.wr_cnt + (s_q.quad ? 5'h04 : 5'h01);
               end
            end
            default: ;
         endcase
      end else if (sclk_fall && (s_q.st == S_OUT)) begin
         if (s_q.out_left == 4'h0) begin
            s_d.out_sh = byte_nx;
            s_d.out_left = BYTE_BITS;
            s_d.idx = (s_q.idx == idx_last) ? 2'h0 : s_q.idx + 2'h1;
         end
         if (s_q.quad) begin
            s_d.sio_tx = s_d.out_sh[7:4];
            s_d.oe_b = 4'h0;
            s_d.out_sh = {s_d.out_sh[3:0], 4'h0};
            s_d.out_left = s_d.out_left - 4'h4;
         end else begin
            s_d.sio_tx = {2'b00, s_d.out_sh[7], 1'b0};
            s_d.oe_b = 4'b1101;
            s_d.out_sh = {s_d.out_sh[6:0], 1'b0};
            s_d.out_left = s_d.out_left - 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= REGS_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign serial_io_line_tx = s_q.sio_tx;
   assign serial_io_line_oe_b = s_q.oe_b;
   assign pe_start = s_q.pe_start;
   assign pe_cmd = s_q.pe_cmd;
   assign reg_write_start = s_q.rw_start;
   assign status_byte = s_q.status;
   assign config_byte = s_q.cfg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence seq_pe_reject;
      ce && cs_rise && pe_try && region_protected;
   endsequence

   sequence seq_latch_gone;
      !s_q.status[ST_LATCH] && !s_q.pe_start;
   endsequence

   busy_bit_a: assert property (ce |=> s_q.status[ST_BUSY] == $past(engine_busy))
      else $error("busy bit does not follow engine");

   latch_done_a: assert property (ce && engine_done && s_q.st != S_CMD |=>
      !s_q.status[ST_LATCH])
      else $error("write latch kept after engine done");

   pe_latch_a: assert property ($rose(s_q.pe_start) |-> $past(s_q.status[ST_LATCH]))
      else $error("program or erase started without write latch");

   protect_reject_a: assert property (seq_pe_reject |=> seq_latch_gone)
      else $error("protected target not rejected");

   chip_erase_a: assert property (s_q.pe_start && (s_q.pe_cmd == CMD_CHIP_ERASE ||
      s_q.pe_cmd == CMD_CHIP_ERASE_ALT) |-> s_q.status[ST_PROT_HI:ST_PROT_LO] == 4'h0)
      else $error("chip erase with protect bits set");

   guard_hold_a: assert property (ce && s_q.nv_loaded && guarded |=>
      s_q.status[ST_LOCK:ST_PROT_LO] == $past(s_q.status[ST_LOCK:ST_PROT_LO]))
      else $error("locked bits changed in guarded mode");

   quad_guard_a: assert property (s_q.status[ST_QUAD] && ce && cs_rise &&
      s_q.st == S_WDATA && s_q.wr_cnt == WR_ONE_BYTE |=> s_q.rw_start)
      else $error("quad enable did not lift pin guard");

   tb_otp_a: assert property (ce && s_q.nv_loaded && s_q.cfg[CF_TB] |=> s_q.cfg[CF_TB])
      else $error("top/bottom select cleared");

   drive_reset_a: assert property (!s_q.nv_loaded |->
      s_q.cfg[CF_DRIVE_HI:0] == DRIVE_30_OHM && !s_q.cfg[CF_WIDE])
      else $error("volatile config defaults wrong");

   out_fall_a: assert property (ce && !cs_s && sclk_fall && s_q.st == S_OUT |=>
      s_q.oe_b != 4'hf ##1 (cs_s || s_q.oe_b != 4'hf))
      else $error("no output on falling clock");

   release_a: assert property (ce && cs_s |=> s_q.oe_b == 4'hf)
      else $error("data lines still driven after deselect");

endmodule

/* verilog/sfsc_pkg.sv */
// Shared constants and types for the flash status and configuration register block
package sfsc_pkg;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_LATCH_SET = 8'h06;
   localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
   localparam logic [7:0] CMD_STATUS_READ = 8'h05;
   localparam logic [7:0] CMD_CONFIG_READ = 8'h15;
   localparam logic [7:0] CMD_REG_WRITE = 8'h01;
   localparam logic [7:0] CMD_ID_READ = 8'h9f;
   localparam logic [7:0] CMD_QUAD_ID_READ = 8'haf;
   localparam logic [7:0] CMD_SIG_READ = 8'hab;
   localparam logic [7:0] CMD_MAKER_DEV_READ = 8'h90;
   localparam logic [7:0] CMD_WIDE_ENTER = 8'hb7;
   localparam logic [7:0] CMD_WIDE_EXIT = 8'he9;
   localparam logic [7:0] CMD_QUAD_ENTER = 8'h35;
   localparam logic [7:0] CMD_QUAD_EXIT = 8'hf5;
   localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h60;
   localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'hc7;
   localparam logic [7:0] CMD_NONE = 8'h00;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_PROT_LO = 2;
   localparam int ST_PROT_HI = 5;
   localparam int ST_QUAD = 6;
   localparam int ST_LOCK = 7;
   localparam int CF_DRIVE_HI = 2;
   localparam int CF_TB = 3;
   localparam int CF_PREAMBLE = 4;
   localparam int CF_WIDE = 5;
   localparam int CF_DUMMY_LO = 6;
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [7:0] CF_RESET = 8'h07;
   localparam logic [2:0] DRIVE_30_OHM = 3'h7;

   // ----------------------------------------------------------------
   // Serial clock and bit counts, last byte indices
   // ----------------------------------------------------------------
   localparam logic [4:0] SPI_OP_CLKS = 5'h08;
   localparam logic [4:0] QUAD_OP_CLKS = 5'h02;
   localparam logic [4:0] SPI_ADDR_CLKS = 5'h18;
   localparam logic [4:0] QUAD_ADDR_CLKS = 5'h06;
   localparam logic [4:0] WR_ONE_BYTE = 5'h08;
   localparam logic [4:0] WR_TWO_BYTES = 5'h10;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] ID_LAST = 2'h2;
   localparam logic [1:0] PAIR_LAST = 2'h1;

   typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_WDATA, S_OUT, S_SKIP} sfsc_state_t;

endpackage

/* verilog/sfsc_sync.sv */
// Two-stage synchroniser for pins arriving from the host
`timescale 1ns/1ps
module sfsc_sync #(
   parameter int W = 6
) (
   input wire logic core_clk, // Block clock
   input wire logic rst_b, // Async reset, active low
   input wire logic ce, // Clock enable
   input wire logic [W-1:0] async_in, // Raw pin levels
   output logic [W-1:0] sync_out // Levels after two flops
);
   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_q[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else if (ce) begin
               meta_q[i] <= async_in[i];
               sync_out[i] <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule

/* verif/sfsc_host.sv */
// Host serial controller model driving the flash link pins
`timescale 1ns/1ps
module sfsc_host (
   input wire logic [3:0] io_tx, // Device drive values
   input wire logic [3:0] io_oe_b, // Device enables, low drives
   input wire logic wp_lvl, // Write-protect pin level in single-line form
   output logic cs_b, // Chip select, active low
   output logic sclk, // Serial clock, runs only inside frames
   output logic [3:0] io_rx // Resolved pin levels seen by the device
);
   logic [3:0] hv;

   // Device drive wins wherever its enable is low
   assign io_rx = (io_oe_b & hv) | (~io_oe_b & io_tx);

   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      hv = 4'hf;
   end

   task automatic clk_one();
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // One frame: opcode, nw data bits, nr output clocks
   // ----------------------------------------------------------------
   task automatic xfer(input logic [7:0] op, input bit qm, input logic [23:0] wd,
                       input int nw, input int nr, output logic [31:0] rd);
      int i;
      rd = '0;
      cs_b = 1'b0;
      #40;
      for (i = 0; i < (qm ? 2 : 8); i++) begin
         hv = qm ? op[7-4*i -: 4] : {1'b1, wp_lvl, 1'b1, op[7-i]};
         clk_one();
      end
      for (i = nw; i > 0; i -= (qm ? 4 : 1)) begin
         hv = qm ? wd[i-1 -: 4] : {1'b1, wp_lvl, 1'b1, wd[i-1]};
         clk_one();
      end
      for (i = 0; i < nr; i++) begin
         // Released lines other than the write-protect pin flip every clock so a stale value cannot pass
         hv = qm ? ~hv : {~hv[3], wp_lvl, ~hv[1:0]};
         #40 sclk = 1'b1;
         rd = qm ? {rd[27:0], io_rx} : {rd[30:0], io_rx[1]};
         #40 sclk = 1'b0;
      end
      cs_b = 1'b1;
      // Write-protect pin keeps its level across deselect
      hv = qm ? ~hv : {~hv[3], wp_lvl, ~hv[1:0]};
      #80;
   endtask
endmodule

/* verif/sfsc_regs_bench.sv */
// Self-checking bench for the flash status and configuration registers
`timescale 1ns/1ps
module sfsc_regs_bench;
   import sfsc_pkg::*;

   logic core_clk, rst_b, ce, cs_b, sclk, wp_lvl;
   logic [3:0] io_rx, io_tx, io_oe_b;
   logic engine_busy, engine_done, region_protected, nv_tb;
   logic [5:0] nv_status_bits;
   logic pe_start, reg_write_start;
   logic [7:0] pe_cmd, status_byte, config_byte;
   logic [31:0] rd;
   bit qm;
   int n_fail, n_tests, n_pe, n_rw, k;

   sfsc_regs u_sfsc_regs (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .cs_b(cs_b),
      .sclk(sclk), .serial_io_line_rx(io_rx), .serial_io_line_tx(io_tx),
      .serial_io_line_oe_b(io_oe_b), .engine_busy(engine_busy), .engine_done(engine_done),
      .region_protected(region_protected), .nv_status_bits(nv_status_bits), .nv_tb(nv_tb),
      .pe_start(pe_start), .pe_cmd(pe_cmd), .reg_write_start(reg_write_start),
      .status_byte(status_byte), .config_byte(config_byte));

   sfsc_host u_sfsc_host (.io_tx(io_tx), .io_oe_b(io_oe_b), .wp_lvl(wp_lvl), .cs_b(cs_b),
      .sclk(sclk), .io_rx(io_rx));

   always #5 core_clk = ~core_clk;

   // Pulses last one cycle, so count them on every edge
   always @(posedge core_clk) begin
      if (pe_start === 1'b1) n_pe++;
      if (reg_write_start === 1'b1) n_rw++;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic io(input logic [7:0] c, input logic [23:0] wd, input int nw, input int nr,
                     input logic [31:0] exp);
      @(negedge core_clk);
      u_sfsc_host.xfer(c, qm, wd, nw, nr, rd);
      if (nr > 0) chk(rd, exp);
   endtask

   task automatic done_pulse();
      @(negedge core_clk);
      engine_done = 1'b1;
      @(negedge core_clk);
      engine_done = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask

   task automatic do_reset();
      rst_b = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask

   task automatic summarize();
      $display("Counts: tests=%0d failures=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      ce = 1'b1;
      wp_lvl = 1'b1;
      engine_busy = 1'b0;
      engine_done = 1'b0;
      region_protected = 1'b0;
      nv_status_bits = 6'h00;
      nv_tb = 1'b0;
      qm = 1'b0;
      do_reset();
      chk(status_byte, 8'h00);
      chk(config_byte, 8'h07);
      io(CMD_STATUS_READ, 24'h0, 0, 8, 32'h00);
      engine_busy = 1'b1;
      io(CMD_STATUS_READ, 24'h0, 0, 16, 32'h0101);
      io(CMD_CONFIG_READ, 24'h0, 0, 16, 32'h0707);
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      engine_busy = 1'b0;
      for (k = 0; k < 20; k++) begin
         @(negedge core_clk);
         u_sfsc_host.xfer(CMD_STATUS_READ, qm, 24'h0, 0, 8, rd);
         if (rd[0] === 1'b0) break;
      end
      if (k == 20) begin
         $display("[ERR] t=%0t poll timeout got=%h exp=%h", $time, rd, 32'h0);
         n_fail++;
         summarize();
      end
      chk(rd, 32'h00);
      // Program refused without the latch, then accepted with it
      io(CMD_PAGE_PROG, 24'h000100, 24, 0, 32'h0);
      chk(n_pe, 0);
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_STATUS_READ, 24'h0, 0, 8, 32'h02);
      // A frozen block must not see the engine's done pulse
      ce = 1'b0;
      done_pulse();
      ce = 1'b1;
      chk(status_byte, 8'h02);
      io(CMD_PAGE_PROG, 24'h000100, 24, 0, 32'h0);
      chk(n_pe, 1);
      chk(pe_cmd, CMD_PAGE_PROG);
      done_pulse();
      chk(status_byte, 8'h00);
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      region_protected = 1'b1;
      io(CMD_SECTOR_ERASE, 24'h001000, 24, 0, 32'h0);
      region_protected = 1'b0;
      chk(n_pe, 1);
      chk(status_byte, 8'h00);
      // Both bytes written in one frame; the address flag bit is not writable
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_REG_WRITE, 24'h0014dd, 16, 0, 32'h0);
      chk(n_rw, 1);
      chk(status_byte, 8'h16);
      chk(config_byte, 8'hdd);
      done_pulse();
      // Writing zero to the top/bottom bit leaves it set
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_REG_WRITE, 24'h0014d5, 16, 0, 32'h0);
      chk(config_byte, 8'hdd);
      done_pulse();
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_CHIP_ERASE, 24'h0, 0, 0, 32'h0);
      chk(n_pe, 1);
      chk(status_byte, 8'h14);
      // Four-line form stays off while quad enable is clear
      io(CMD_QUAD_ENTER, 24'h0, 0, 0, 32'h0);
      io(CMD_STATUS_READ, 24'h0, 0, 8, 32'h14);
      io(CMD_WIDE_ENTER, 24'h0, 0, 0, 32'h0);
      chk(config_byte, 8'hfd);
      io(CMD_WIDE_EXIT, 24'h0, 0, 0, 32'h0);
      chk(config_byte, 8'hdd);
      // Lock with the pin low blocks writes until quad enable is set
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_REG_WRITE, 24'h000080, 8, 0, 32'h0);
      done_pulse();
      wp_lvl = 1'b0;
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_REG_WRITE, 24'h000000, 8, 0, 32'h0);
      chk(n_rw, 3);
      chk(status_byte[7:2], 6'h20);
      wp_lvl = 1'b1;
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_REG_WRITE, 24'h0000c0, 8, 0, 32'h0);
      done_pulse();
      wp_lvl = 1'b0;
      io(CMD_LATCH_SET, 24'h0, 0, 0, 32'h0);
      io(CMD_REG_WRITE, 24'h000040, 8, 0, 32'h0);
      chk(status_byte[7:2], 6'h10);
      done_pulse();
      wp_lvl = 1'b1;
      // Four-line form, then identification reads in both forms
      io(CMD_QUAD_ENTER, 24'h0, 0, 0, 32'h0);
      qm = 1'b1;
      io(CMD_QUAD_ID_READ, 24'h0, 0, 8, 32'h5a3c445a);
      // The refused ID opcode leaves the lines released and flipping; status and config reads still answer
      io(CMD_ID_READ, 24'h0, 0, 2, 32'h0f);
      io(CMD_STATUS_READ, 24'h0, 0, 2, 32'h40);
      io(CMD_CONFIG_READ, 24'h0, 0, 2, 32'hdd);
      io(CMD_QUAD_EXIT, 24'h0, 0, 0, 32'h0);
      qm = 1'b0;
      io(CMD_QUAD_ID_READ, 24'h0, 0, 8, 32'h55);
      io(CMD_ID_READ, 24'h0, 0, 32, 32'h5a3c445a);
      io(CMD_SIG_READ, 24'h0, 0, 16, 32'h2727);
      io(CMD_MAKER_DEV_READ, 24'h000001, 24, 16, 32'h275a);
      io(CMD_MAKER_DEV_READ, 24'h000000, 24, 16, 32'h5a27);
      // Stored bits come back after a second reset
      nv_status_bits = 6'h0f;
      nv_tb = 1'b1;
      do_reset();
      chk(status_byte, 8'h3c);
      chk(config_byte, 8'h0f);
      summarize();
   end
endmodule
